/* src/fds_pkg.sv */
// Purpose: shared constants and types for the fan duty slope block
// Assumes: APB with 32-bit data, 8-bit temperatures in 1 degree steps
// Notes:   slope table holds 170/range scaled by 2^8 (duty per degree, Q8)
package fds_pkg;
  localparam int          FDS_NCH          = 3;
  localparam int          FDS_AW           = 12;
  // slope registers: word index; byte address is four times it
  localparam logic [11:0] FDS_OFF_R1_SLOPE = 12'h05F;
  localparam logic [11:0] FDS_OFF_LC_SLOPE = 12'h060;
  localparam logic [11:0] FDS_OFF_R2_SLOPE = 12'h061;
  localparam logic [11:0] FDS_OFF_TSTART0  = 12'h100;
  localparam logic [11:0] FDS_OFF_MINDUTY0 = 12'h110;
  localparam logic [11:0] FDS_OFF_MAXDUTY0 = 12'h120;
  localparam logic [11:0] FDS_OFF_TEMP0    = 12'h130;
  localparam logic [11:0] FDS_OFF_DUTY0    = 12'h140;
  localparam logic [11:0] FDS_OFF_STATUS   = 12'h150;
  localparam logic [7:0]  FDS_SLOPE_RST    = 8'hC0;
  localparam logic [7:0]  FDS_TSTART_RST   = 8'h9A;
  localparam logic [7:0]  FDS_MINDUTY_RST  = 8'h80;
  localparam logic [7:0]  FDS_MAXDUTY_RST  = 8'hFF;
  localparam logic [7:0]  FDS_FULL_DUTY    = 8'hFF;
  localparam int          FDS_SEL_LSB      = 4;
  localparam int          FDS_FRAC         = 8;

  typedef struct packed {
    logic [7:0] tStart;
    logic [7:0] minDuty;
    logic [7:0] maxDuty;
    logic [3:0] slopeSel;
  } fds_chcfg_t;

  // duty steps per degree in Q8: 170/range*256, rounded
  function automatic logic [15:0] fds_slope_q8(input logic [3:0] sel);
    case (sel)
      4'h0:    return 16'h5500;
      4'h1:    return 16'h4400;
      4'h2:    return 16'h3300;
      4'h3:    return 16'h2A80;
      4'h4:    return 16'h2200;
      4'h5:    return 16'h1980;
      4'h6:    return 16'h1540;
      4'h7:    return 16'h1100;
      4'h8:    return 16'h0CC0;
      4'h9:    return 16'h0AA0;
      4'hA:    return 16'h0880;
      4'hB:    return 16'h0660;
      4'hC:    return 16'h0550;
      4'hD:    return 16'h0440;
      4'hE:    return 16'h0330;
      default: return 16'h0220;
    endcase
  endfunction : fds_slope_q8
endpackage : fds_pkg

/* src/fds_slope_ctrl.sv */
// Purpose: per-channel slope duty computation with APB register file
// Assumes: temperatures arrive synchronous to mclk, unsigned 1 degree codes
// Notes:   duty updates one cycle after temperature or settings change
//          slope registers sit at four times their word index
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ns
module fds_slope_ctrl #(
  parameter int NCH = fds_pkg::FDS_NCH
) (
  input  wire logic                  mclk,      // 100 MHz clock
  input  wire logic                  srst,      // sync reset, high
  input  wire logic                  psel,      // apb select
  input  wire logic                  penable,   // apb enable
  input  wire logic                  pwrite,    // apb direction
  input  wire logic [11:0]           paddr,     // apb byte address
  input  wire logic [31:0]           pwdata,    // apb write data
  output logic      [31:0]           prdata,    // apb read data
  output logic                       pready,    // apb ready
  output logic                       pslverr,   // apb error
  input  wire logic [NCH-1:0][7:0]   chanTemp,  // measured temperatures
  output logic      [NCH-1:0][7:0]   dutyOut    // computed duty codes
);
  import fds_pkg::*;

  fds_chcfg_t        cfg_ff [NCH];
  logic [NCH-1:0]    active;
  logic [7:0]        nxtDuty [NCH];
  logic [NCH-1:0][7:0] duty_ff;
  logic              acc;
  logic              hit;
  logic [31:0]       rdMux;
  logic [31:0]       rdData_ff;

  assign acc     = psel & penable;
  assign pready  = 1'b1;

  // register writes
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        cfg_ff[i].slopeSel <= FDS_SLOPE_RST[7:FDS_SEL_LSB];
        cfg_ff[i].tStart   <= FDS_TSTART_RST;
        cfg_ff[i].minDuty  <= FDS_MINDUTY_RST;
        cfg_ff[i].maxDuty  <= FDS_MAXDUTY_RST;
      end
    end
    else if (acc && pwrite)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        if (paddr == (FDS_OFF_R1_SLOPE + 12'(i)) << 2)
          cfg_ff[i].slopeSel <= pwdata[7:FDS_SEL_LSB];
        if (paddr == FDS_OFF_TSTART0 + 12'(4 * i))
          cfg_ff[i].tStart <= pwdata[7:0];
        if (paddr == FDS_OFF_MINDUTY0 + 12'(4 * i))
          cfg_ff[i].minDuty <= pwdata[7:0];
        if (paddr == FDS_OFF_MAXDUTY0 + 12'(4 * i))
          cfg_ff[i].maxDuty <= pwdata[7:0];
      end
    end
  end

  // read decode; unmapped reads zero with pslverr
  always_comb
  begin
    rdMux = 32'h0;
    hit   = 1'b0;
    for (int i = 0; i < NCH; i++)
    begin
      if (paddr == (FDS_OFF_R1_SLOPE + 12'(i)) << 2)
      begin
        rdMux = {24'h0, cfg_ff[i].slopeSel, 4'h0};
        hit   = 1'b1;
      end
      if (paddr == FDS_OFF_TSTART0 + 12'(4 * i))
      begin
        rdMux = {24'h0, cfg_ff[i].tStart};
        hit   = 1'b1;
      end
      if (paddr == FDS_OFF_MINDUTY0 + 12'(4 * i))
      begin
        rdMux = {24'h0, cfg_ff[i].minDuty};
        hit   = 1'b1;
      end
      if (paddr == FDS_OFF_MAXDUTY0 + 12'(4 * i))
      begin
        rdMux = {24'h0, cfg_ff[i].maxDuty};
        hit   = 1'b1;
      end
      if (paddr == FDS_OFF_TEMP0 + 12'(4 * i))
      begin
        rdMux = {24'h0, chanTemp[i]};
        hit   = 1'b1;
      end
      if (paddr == FDS_OFF_DUTY0 + 12'(4 * i))
      begin
        rdMux = {24'h0, duty_ff[i]};
        hit   = 1'b1;
      end
    end
    if (paddr == FDS_OFF_STATUS)
    begin
      rdMux = {{(32 - NCH){1'b0}}, active};
      hit   = 1'b1;
    end
  end

  assign pslverr = acc & ~hit;
  assign prdata  = rdData_ff;

  // read word captured in setup so it stands from a flop in access
  always_ff @(posedge mclk)
  begin
    if (srst)
      rdData_ff <= 32'h0;
    else if (psel && !penable && !pwrite)
      rdData_ff <= rdMux;
    else
      rdData_ff <= 32'h0;
  end

  // slope duty: min + (temp - start) * 170/range, clipped
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      logic [8:0]  dT;
      logic [24:0] prod;
      logic [16:0] sum;
      dT   = {1'b0, chanTemp[i]} - {1'b0, cfg_ff[i].tStart};
      active[i] = chanTemp[i] > cfg_ff[i].tStart;
      // degrees above start, slope fixed whatever the minimum
      prod = 25'(dT) * 25'(fds_slope_q8(cfg_ff[i].slopeSel));
      sum  = 17'(prod >> FDS_FRAC) + {9'h0, cfg_ff[i].minDuty};
      if (!active[i])
        nxtDuty[i] = 8'h00;
      else if (sum > {9'h0, cfg_ff[i].maxDuty})
        nxtDuty[i] = cfg_ff[i].maxDuty;
      else if (sum > {9'h0, FDS_FULL_DUTY})
        nxtDuty[i] = FDS_FULL_DUTY;
      else
        nxtDuty[i] = sum[7:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      duty_ff <= '0;
    else
      for (int i = 0; i < NCH; i++)
        duty_ff[i] <= nxtDuty[i];
  end

  assign dutyOut = duty_ff;

  // output checks; channel 0 carries the worked slope cases
  AST_MAXCLIP: assert property (@(posedge mclk) disable iff (srst)
    dutyOut[0] <= cfg_ff[0].maxDuty || $changed(cfg_ff[0].maxDuty))
    else $error("duty above maximum duty");
  AST_IDLEZERO: assert property (@(posedge mclk) disable iff (srst)
    !active[1] |=> dutyOut[1] == 8'h00)
    else $error("duty nonzero below start temperature");
  AST_BELOWSTART: assert property (@(posedge mclk) disable iff (srst)
    (chanTemp[0] <= cfg_ff[0].tStart) |=> dutyOut[0] == 8'h00)
    else $error("slope duty computed at or below start temperature");

  // slope start and per-degree step
  AST_FIRSTMIN: assert property (@(posedge mclk) disable iff (srst)
    (chanTemp[0] == cfg_ff[0].tStart + 8'h01 && cfg_ff[0].tStart != 8'hFF
     && cfg_ff[0].slopeSel == 4'hD && cfg_ff[0].minDuty <= 8'hF0
     && cfg_ff[0].maxDuty == 8'hFF)
    |=> dutyOut[0] == $past(cfg_ff[0].minDuty) + 8'h04)
    else $error("slope does not start from minimum duty");
  AST_SLOPE3: assert property (@(posedge mclk) disable iff (srst)
    (chanTemp[0] == cfg_ff[0].tStart + 8'd2 && cfg_ff[0].tStart <= 8'hF0
     && cfg_ff[0].slopeSel == 4'hD && cfg_ff[0].minDuty <= 8'hF0
     && cfg_ff[0].maxDuty == 8'hFF)
    |=> dutyOut[0] == $past(cfg_ff[0].minDuty) + 8'h08)
    else $error("slope per degree depends on minimum duty");
  AST_ACTIVE: assert property (@(posedge mclk) disable iff (srst)
    (chanTemp[2] > cfg_ff[2].tStart && cfg_ff[2].maxDuty != 8'h00
     && cfg_ff[2].minDuty != 8'h00) |=> dutyOut[2] != 8'h00)
    else $error("no duty above start temperature");

  // full-speed temperature
  AST_RANGE40: assert property (@(posedge mclk) disable iff (srst)
    (cfg_ff[0].slopeSel == 4'hD && cfg_ff[0].minDuty == 8'h55
     && cfg_ff[0].maxDuty == 8'hFF && cfg_ff[0].tStart <= 8'hA0
     && chanTemp[0] == cfg_ff[0].tStart + 8'd40) |=> dutyOut[0] == 8'hFF)
    else $error("full duty not reached at start plus range");
  AST_EFFRANGE: assert property (@(posedge mclk) disable iff (srst)
    (cfg_ff[0].slopeSel == 4'hD && cfg_ff[0].minDuty == 8'h1A
     && cfg_ff[0].maxDuty == 8'hFF && cfg_ff[0].tStart <= 8'hA0
     && chanTemp[0] == cfg_ff[0].tStart + 8'd54) |=> dutyOut[0] == 8'hFF)
    else $error("full duty not reached at effective range");
  AST_BEFOREFULL: assert property (@(posedge mclk) disable iff (srst)
    (cfg_ff[0].slopeSel == 4'hD && cfg_ff[0].minDuty == 8'h1A
     && cfg_ff[0].maxDuty == 8'hFF && cfg_ff[0].tStart <= 8'hA0
     && chanTemp[0] == cfg_ff[0].tStart + 8'd53) |=> dutyOut[0] == 8'hFB)
    else $error("duty off slope one degree before full speed");

  // register side and duty saturation
  AST_SLOPESEL: assert property (@(posedge mclk) disable iff (srst)
    (acc && pwrite && paddr == (FDS_OFF_LC_SLOPE << 2))
    |=> cfg_ff[1].slopeSel == $past(pwdata[7:4]))
    else $error("local slope select not written");
  AST_RSTSEL: assert property (@(posedge mclk)
    srst |=> cfg_ff[2].slopeSel == 4'hC)
    else $error("slope select reset code wrong");
  AST_SAT: assert property (@(posedge mclk) disable iff (srst)
    (active[0] && cfg_ff[0].maxDuty == 8'hFF && chanTemp[0] == 8'hFF
     && cfg_ff[0].tStart < 8'h02 && cfg_ff[0].slopeSel == 4'h0)
    |=> dutyOut[0] == 8'hFF)
    else $error("duty wrapped instead of saturating");
endmodule : fds_slope_ctrl

/* tb/fds_fan_model.sv */
// Purpose: fan on the far side of one duty output
// Assumes: duty code 0..255, speed follows with inertia
// Notes:   speed moves one step a cycle toward duty
`timescale 1ns/1ns
module fds_fan_model (
  input  wire logic       mclk,  // clock
  input  wire logic [7:0] duty,  // duty code in
  output logic      [7:0] speed  // speed estimate
);
  logic [7:0] speed_ff = 8'h00;
  assign speed = speed_ff;
  always_ff @(posedge mclk)
  begin
    if (speed_ff < duty)
      speed_ff <= speed_ff + 8'h01;
    else if (speed_ff > duty)
      speed_ff <= speed_ff - 8'h01;
  end
endmodule : fds_fan_model

/* tb/tb.sv */
// Purpose: self-checking bench for the slope duty block
// Assumes: zero-wait APB, duty one cycle after inputs
// Notes:   fan model hangs on channel 0
`timescale 1ns/1ns
module tb;
  import fds_pkg::*;
  localparam int R6[16] = '{12, 15, 20, 24, 30, 40, 48, 60, 80, 96, 120, 160, 192, 240, 320, 480};
  logic            mclk = 1'b0;
  logic            srst = 1'b1;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic [11:0]     paddr = 12'h000;
  logic [31:0]     pwdata = 32'h0;
  logic [31:0]     prdata, rd;
  logic            pready, pslverr, err;
  logic [2:0][7:0] chanTemp = '0;
  logic [2:0][7:0] dutyOut;
  logic [7:0]      fanSpeed;
  int              n_mismatch = 0;
  int              total_checks = 0;
  always #5 mclk = ~mclk;
  fds_slope_ctrl dut (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chanTemp(chanTemp), .dutyOut(dutyOut));
  fds_fan_model fan (.mclk(mclk), .duty(dutyOut[0]), .speed(fanSpeed));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task tchk(input int ch, input logic [7:0] t, input logic [7:0] exp);
    chanTemp[ch] <= t;
    repeat (2) @(posedge mclk);
    chk({24'h0, dutyOut[ch]}, {24'h0, exp});
  endtask : tchk
  task t_reset;
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b0, (FDS_OFF_R1_SLOPE + 12'(i)) << 2, 32'h0);
      chk(rd, 32'h000000C0);
    end
    apb(1'b0, FDS_OFF_MAXDUTY0, 32'h0);
    chk(rd, 32'h000000FF);
    chk({24'h0, dutyOut[0]}, 32'h0);
  endtask : t_reset
  task t_slope;
    apb(1'b1, FDS_OFF_TSTART0, 32'h1E);
    apb(1'b1, FDS_OFF_MINDUTY0, 32'h55);
    apb(1'b1, FDS_OFF_R1_SLOPE << 2, 32'hD0);
    tchk(0, 8'h1E, 8'h00);
    tchk(0, 8'h1F, 8'h59);
    tchk(0, 8'h45, 8'hFA);
    tchk(0, 8'h46, 8'hFF);
    tchk(0, 8'hC8, 8'hFF);
  endtask : t_slope
  task t_minmax;
    apb(1'b1, FDS_OFF_MINDUTY0, 32'h80);
    tchk(0, 8'h20, 8'h88);
    apb(1'b1, FDS_OFF_MINDUTY0, 32'h1A);
    tchk(0, 8'h53, 8'hFB);
    tchk(0, 8'h54, 8'hFF);
    apb(1'b1, FDS_OFF_MAXDUTY0, 32'hC0);
    tchk(0, 8'h55, 8'hC0);
  endtask : t_minmax
  task t_codes;
    apb(1'b1, FDS_OFF_TSTART0 + 12'h8, 32'h10);
    apb(1'b1, FDS_OFF_MINDUTY0 + 12'h8, 32'h00);
    for (int c = 0; c < 16; c++)
    begin
      apb(1'b1, FDS_OFF_R2_SLOPE << 2, {24'h0, 4'(c), 4'hF});
      apb(1'b0, FDS_OFF_R2_SLOPE << 2, 32'h0);
      chk(rd, {24'h0, 4'(c), 4'h0});
      tchk(2, 8'h11, 8'((261120 + R6[c] / 2) / R6[c] / 256));
    end
    apb(1'b0, FDS_OFF_R1_SLOPE << 2, 32'h0);
    chk(rd, 32'h000000D0);
    chk({24'h0, dutyOut[1]}, 32'h0);
  endtask : t_codes
  task t_sat;
    apb(1'b1, FDS_OFF_TSTART0, 32'h01);
    apb(1'b1, FDS_OFF_R1_SLOPE << 2, 32'h00);
    apb(1'b1, FDS_OFF_MAXDUTY0, 32'hFF);
    tchk(0, 8'hFF, 8'hFF);
    repeat (256) @(posedge mclk);
    chk({24'h0, fanSpeed}, 32'hFF);
    apb(1'b1, FDS_OFF_LC_SLOPE << 2, 32'h70);
    apb(1'b0, FDS_OFF_LC_SLOPE << 2, 32'h0);
    chk(rd, 32'h00000070);
    apb(1'b1, FDS_OFF_TSTART0 + 12'h4, 32'h20);
    apb(1'b1, FDS_OFF_MINDUTY0 + 12'h4, 32'h10);
    tchk(1, 8'h22, 8'h32);
  endtask : t_sat
  task t_unmapped;
    apb(1'b1, 12'h0FC, 32'hFF);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 12'h0FC, 32'h0);
    chk(rd, 32'h0);
  endtask : t_unmapped
  task results;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  initial
  begin
    #100000;
    n_mismatch++;
    results;
  end
  initial
  begin
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    t_reset;
    t_slope;
    t_minmax;
    t_codes;
    t_sat;
    t_unmapped;
    results;
  end
endmodule : tb
